// *** verilog/hsi_pkg.sv ***
// Notes on behaviour
// - Slave link is mode 3; host clock up to 1.625MHz
// - Eight-bit words, select active low only
// - Shared-select or sole-slave select arrangement selectable
// - Async link: 57600 baud, 8N1 both ways
// - No flow control on the async link
// - Host-controller mode uses only the async link
// - Low wake pin ends sleep, restarts oscillator
// - Boot samples receive pin; mode fixed till reset
package hsi_pkg;
   // ==========================================================
   // Timing
   localparam int CLK_HZ = 10_000_000;
   localparam int BAUD_BPS = 57600;
   localparam int BAUD_DIV = (CLK_HZ + BAUD_BPS / 2) / BAUD_BPS;
   localparam int SPI_MAX_HZ = 1_625_000;
   localparam int WORD_BITS = 8;
   localparam int STOP_BITS = 1;
   localparam logic [1:0] BOOT_SAMPLE = 2'h2;
   // ==========================================================
   // Register map
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_STAT = 4'h4;
   localparam logic [3:0] OFS_TXDATA = 4'h8;
   localparam logic [3:0] OFS_RXDATA = 4'hC;
   localparam int CTRL_SINGLE_BIT = 0;
   localparam int CTRL_SLEEP_BIT = 1;
   localparam int STAT_HCI_BIT = 0;
   localparam int STAT_ASLEEP_BIT = 1;
   localparam int STAT_RXV_BIT = 2;
   localparam int STAT_TXF_BIT = 3;
   localparam logic CTRL_SINGLE_RST = 1'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ==========================================================
   // Types
   typedef enum logic [3:0] {
      U_IDLE = 4'h1,
      U_START = 4'h2,
      U_DATA = 4'h4,
      U_STOP = 4'h8
   } hsi_uart_e;
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } hsi_byte_s;
endpackage

// *** verilog/hsi_uart.sv ***
`timescale 1ns/100ps
module hsi_uart #(
   parameter int DIV = hsi_pkg::BAUD_DIV
) (
   input wire logic clk_in, // System clock
   input wire logic rstn_in, // Sync reset, low
   input wire logic en_in, // Link enabled
   input wire hsi_pkg::hsi_byte_s tx_in, // Byte to send
   output logic tx_ready_out, // Transmitter idle
   output hsi_pkg::hsi_byte_s rx_out, // Received byte pulse
   input wire logic rxd_in, // Synchronised receive line
   output logic txd_out // Transmit line
);
   import hsi_pkg::*;
   localparam int CW = $clog2(DIV);
   hsi_uart_e rx_st_q, tx_st_q;
   logic [CW-1:0] rx_cnt_q, tx_cnt_q;
   logic [2:0] rx_bit_q, tx_bit_q;
   logic [7:0] rx_sh_q, tx_sh_q;
   logic txd_q;
   hsi_byte_s rx_q;
   wire rx_tick = rx_cnt_q == '0;
   wire tx_tick = tx_cnt_q == '0;
   assign tx_ready_out = tx_st_q == U_IDLE;
   assign rx_out = rx_q;
   assign txd_out = txd_q;

   // ==========================================================
   // Receiver, centre sampled
   always_ff @(posedge clk_in) begin
      if (!rstn_in || !en_in) begin
         rx_st_q <= U_IDLE;
         rx_cnt_q <= '0;
         rx_bit_q <= '0;
         rx_sh_q <= '0;
         rx_q <= '0;
      end else begin
         rx_q.valid <= 1'b0;
         if (!rx_tick) rx_cnt_q <= rx_cnt_q - 1'b1;
         case (rx_st_q)
            U_IDLE: if (!rxd_in) begin
               rx_st_q <= U_START;
               rx_cnt_q <= CW'(DIV / 2);
            end
            U_START: if (rx_tick) begin
               rx_st_q <= rxd_in ? U_IDLE : U_DATA;
               rx_cnt_q <= CW'(DIV - 1);
               rx_bit_q <= '0;
            end
            U_DATA: if (rx_tick) begin
               rx_sh_q <= {rxd_in, rx_sh_q[7:1]};
               rx_cnt_q <= CW'(DIV - 1);
               rx_bit_q <= rx_bit_q + 1'b1;
               if (rx_bit_q == 3'h7) rx_st_q <= U_STOP;
            end
            U_STOP: if (rx_tick) begin
               rx_st_q <= U_IDLE;
               rx_q.valid <= rxd_in;
               rx_q.data <= rx_sh_q;
            end
            default: rx_st_q <= U_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Transmitter, starts without any handshake
   always_ff @(posedge clk_in) begin
      if (!rstn_in || !en_in) begin
         tx_st_q <= U_IDLE;
         tx_cnt_q <= '0;
         tx_bit_q <= '0;
         tx_sh_q <= '0;
         txd_q <= 1'b1;
      end else begin
         if (!tx_tick) tx_cnt_q <= tx_cnt_q - 1'b1;
         case (tx_st_q)
            U_IDLE: if (tx_in.valid) begin
               tx_sh_q <= tx_in.data;
               txd_q <= 1'b0;
               tx_cnt_q <= CW'(DIV - 1);
               tx_st_q <= U_START;
            end
            U_START: if (tx_tick) begin
               txd_q <= tx_sh_q[0];
               tx_sh_q <= {1'b0, tx_sh_q[7:1]};
               tx_cnt_q <= CW'(DIV - 1);
               tx_bit_q <= '0;
               tx_st_q <= U_DATA;
            end
            U_DATA: if (tx_tick) begin
               tx_cnt_q <= CW'(DIV - 1);
               if (tx_bit_q == 3'h7) begin
                  txd_q <= 1'b1;
                  tx_st_q <= U_STOP;
               end else begin
                  txd_q <= tx_sh_q[0];
                  tx_sh_q <= {1'b0, tx_sh_q[7:1]};
                  tx_bit_q <= tx_bit_q + 1'b1;
               end
            end
            U_STOP: if (tx_tick) tx_st_q <= U_IDLE;
            default: tx_st_q <= U_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Checks
   uart_stop_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      (tx_st_q == U_STOP) |-> txd_q) else $error("stop bit not high");
   uart_start_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      (en_in && tx_st_q == U_IDLE && tx_in.valid) |=> !txd_q ##0 tx_st_q == U_START)
      else $error("transmit did not start at once");
   uart_frame_a: assert property (@(posedge clk_in) disable iff (!rstn_in || !en_in)
      rx_q.valid |-> $past(rx_st_q) == U_STOP && $past(rxd_in))
      else $error("byte taken without stop bit");
endmodule

// *** verilog/hsi_top.sv ***
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module hsi_top (
   input wire logic clk_in, // System clock 10 MHz
   input wire logic rstn_in, // Reset, low; sync for clk_in logic, async for the serial slave link logic
   input wire logic [3:0] s_axi_awaddr_in, // Write address
   input wire logic s_axi_awvalid_in, // Write address valid
   output logic s_axi_awready_out, // Write address ready
   input wire logic [31:0] s_axi_wdata_in, // Write data
   input wire logic [3:0] s_axi_wstrb_in, // Write strobes
   input wire logic s_axi_wvalid_in, // Write data valid
   output logic s_axi_wready_out, // Write data ready
   output logic [1:0] s_axi_bresp_out, // Write response
   output logic s_axi_bvalid_out, // Write response valid
   input wire logic s_axi_bready_in, // Write response ready
   input wire logic [3:0] s_axi_araddr_in, // Read address
   input wire logic s_axi_arvalid_in, // Read address valid
   output logic s_axi_arready_out, // Read address ready
   output logic [31:0] s_axi_rdata_out, // Read data
   output logic [1:0] s_axi_rresp_out, // Read response
   output logic s_axi_rvalid_out, // Read data valid
   input wire logic s_axi_rready_in, // Read data ready
   input wire logic spi_sclk_in, // Serial clock from host
   input wire logic spi_cs_n_in, // Select, low
   input wire logic spi_mosi_in, // Serial data in
   output logic spi_miso_out, // Serial data out
   output logic spi_miso_oe_out, // Serial data out enable
   input wire logic uart_rxd_in, // Async receive pin
   output logic uart_txd_out, // Async transmit pin
   input wire logic wake_req_n_in, // Wake request, low
   input wire logic alternate_wake_pin_n_in, // Alternate wake, low
   output logic osc_start_out, // Oscillator restart pulse
   output logic osc_en_out // Oscillator enable
);
   import hsi_pkg::*;

   function automatic logic ofs_hit(input logic [3:0] a);
      ofs_hit = a == OFS_CTRL || a == OFS_STAT || a == OFS_TXDATA || a == OFS_RXDATA;
   endfunction

   // ==========================================================
   // Pin synchronisers
   logic [4:0] sy1_q, sy2_q;
   always_ff @(posedge clk_in) begin
      sy1_q <= {spi_cs_n_in, wake_req_n_in, alternate_wake_pin_n_in, uart_rxd_in, 1'b0};
      sy2_q <= sy1_q;
   end
   wire cs_n_s = sy2_q[4];
   wire wake_s = !sy2_q[3] || !sy2_q[2];
   wire rxd_s = sy2_q[1];

   // ==========================================================
   // Boot mode capture
   logic [1:0] boot_cnt_q;
   logic boot_done_q, hci_mode_q;
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         boot_cnt_q <= '0;
         boot_done_q <= 1'b0;
         hci_mode_q <= 1'b0;
      end else if (!boot_done_q) begin
         boot_cnt_q <= boot_cnt_q + 1'b1;
         if (boot_cnt_q == BOOT_SAMPLE) begin
            hci_mode_q <= rxd_s;
            boot_done_q <= 1'b1;
         end
      end
   end
   wire spi_on = boot_done_q && !hci_mode_q;
   wire uart_on = boot_done_q && hci_mode_q;

   // ==========================================================
   // Serial slave, link clock domain
   logic [2:0] bit_cnt_q;
   logic [6:0] sh_q;
   logic [7:0] rx_word_q, tx_sh_q;
   logic rx_tog_q, miso_q, ack_tog_q, req_l1_q, req_l2_q;
   logic [7:0] tx_hold_q;
   logic tx_req_q;
   always_ff @(posedge spi_sclk_in or posedge spi_cs_n_in) begin
      if (spi_cs_n_in) bit_cnt_q <= '0;
      else bit_cnt_q <= bit_cnt_q + 1'b1;
   end
   always_ff @(posedge spi_sclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         sh_q <= '0;
         rx_word_q <= '0;
         rx_tog_q <= 1'b0;
      end else if (!spi_cs_n_in) begin
         sh_q <= {sh_q[5:0], spi_mosi_in};
         if (bit_cnt_q == 3'h7) begin
            rx_word_q <= {sh_q, spi_mosi_in};
            rx_tog_q <= !rx_tog_q;
         end
      end
   end
   wire tx_take = req_l2_q != ack_tog_q;
   wire [7:0] tx_word = tx_take ? tx_hold_q : 8'h00;
   always_ff @(negedge spi_sclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         req_l1_q <= 1'b0;
         req_l2_q <= 1'b0;
         ack_tog_q <= 1'b0;
         miso_q <= 1'b0;
         tx_sh_q <= '0;
      end else if (!spi_cs_n_in) begin
         req_l1_q <= tx_req_q;
         req_l2_q <= req_l1_q;
         if (bit_cnt_q == 3'h0) begin
            miso_q <= tx_word[7];
            tx_sh_q <= {tx_word[6:0], 1'b0};
            ack_tog_q <= req_l2_q;
         end else begin
            miso_q <= tx_sh_q[7];
            tx_sh_q <= {tx_sh_q[6:0], 1'b0};
         end
      end
   end
   assign spi_miso_out = miso_q;

   // ==========================================================
   // Crossings back to the system clock
   logic rxt1_q, rxt2_q, rxt3_q, ack1_q, ack2_q;
   always_ff @(posedge clk_in) begin
      rxt1_q <= rx_tog_q;
      rxt2_q <= rxt1_q;
      rxt3_q <= rxt2_q;
      ack1_q <= ack_tog_q;
      ack2_q <= ack1_q;
   end
   wire spi_rx_evt = spi_on && (rxt2_q != rxt3_q);
   wire spi_tx_full = tx_req_q != ack2_q;

   // ==========================================================
   // Async link
   hsi_byte_s u_tx, u_rx;
   logic u_tx_rdy, tx_pend_q;
   assign u_tx.valid = tx_pend_q;
   assign u_tx.data = tx_hold_q;
   hsi_uart u_uart (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .en_in(uart_on),
      .tx_in(u_tx),
      .tx_ready_out(u_tx_rdy),
      .rx_out(u_rx),
      .rxd_in(rxd_s),
      .txd_out(uart_txd_out)
   );

   // ==========================================================
   // Register bus
   logic aw_got_q, w_got_q;
   logic [3:0] awaddr_q, araddr_q;
   logic [31:0] wdata_q;
   logic wstrb0_q;
   logic single_q, asleep_q, rx_valid_q, osc_start_q, miso_oe_q, osc_en_q;
   logic [7:0] rx_data_q;
   wire aw_take = s_axi_awvalid_in && s_axi_awready_out;
   wire w_take = s_axi_wvalid_in && s_axi_wready_out;
   wire ar_take = s_axi_arvalid_in && s_axi_arready_out;
   wire wr_go = aw_got_q && w_got_q && !s_axi_bvalid_out;
   wire wr_en = wr_go && wstrb0_q;
   wire wr_ctrl = wr_en && awaddr_q == OFS_CTRL;
   wire wr_tx = wr_en && awaddr_q == OFS_TXDATA;
   wire rd_rx = ar_take && s_axi_araddr_in == OFS_RXDATA;
   wire tx_full = hci_mode_q ? tx_pend_q : spi_tx_full;
   wire [31:0] stat_word = {28'h0, tx_full, rx_valid_q, asleep_q, hci_mode_q};
   wire [31:0] rd_mux = s_axi_araddr_in == OFS_CTRL ? {31'h0, single_q} :
                        s_axi_araddr_in == OFS_STAT ? stat_word :
                        s_axi_araddr_in == OFS_RXDATA ? {24'h0, rx_data_q} : 32'h0;
   wire new_rx = spi_rx_evt || (uart_on && u_rx.valid);
   wire [7:0] new_byte = hci_mode_q ? u_rx.data : rx_word_q;

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         s_axi_awready_out <= 1'b0;
         s_axi_wready_out <= 1'b0;
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out <= RESP_OKAY;
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= '0;
         wstrb0_q <= 1'b0;
      end else begin
         s_axi_awready_out <= s_axi_awvalid_in && !s_axi_awready_out && !aw_got_q
                              && !s_axi_bvalid_out;
         s_axi_wready_out <= s_axi_wvalid_in && !s_axi_wready_out && !w_got_q
                             && !s_axi_bvalid_out;
         if (aw_take) begin
            aw_got_q <= 1'b1;
            awaddr_q <= s_axi_awaddr_in;
         end
         if (w_take) begin
            w_got_q <= 1'b1;
            wdata_q <= s_axi_wdata_in;
            wstrb0_q <= s_axi_wstrb_in[0];
         end
         if (wr_go) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out <= ofs_hit(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         s_axi_arready_out <= 1'b0;
         s_axi_rvalid_out <= 1'b0;
         s_axi_rdata_out <= '0;
         s_axi_rresp_out <= RESP_OKAY;
      end else begin
         s_axi_arready_out <= s_axi_arvalid_in && !s_axi_arready_out && !s_axi_rvalid_out;
         if (ar_take) begin
            s_axi_rvalid_out <= 1'b1;
            s_axi_rdata_out <= rd_mux;
            s_axi_rresp_out <= ofs_hit(s_axi_araddr_in) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Data, select arrangement and power state
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         single_q <= CTRL_SINGLE_RST;
         asleep_q <= 1'b0;
         osc_start_q <= 1'b0;
         osc_en_q <= 1'b1;
         rx_valid_q <= 1'b0;
         rx_data_q <= '0;
         tx_hold_q <= '0;
         tx_req_q <= 1'b0;
         tx_pend_q <= 1'b0;
         miso_oe_q <= 1'b0;
      end else begin
         if (wr_ctrl) single_q <= wdata_q[CTRL_SINGLE_BIT];
         osc_start_q <= asleep_q && wake_s;
         if (asleep_q && wake_s) begin
            asleep_q <= 1'b0;
            osc_en_q <= 1'b1;
         end else if (wr_ctrl && wdata_q[CTRL_SLEEP_BIT]) begin
            asleep_q <= 1'b1;
            osc_en_q <= 1'b0;
         end
         if (new_rx) begin
            rx_valid_q <= 1'b1;
            rx_data_q <= new_byte;
         end else if (rd_rx) begin
            rx_valid_q <= 1'b0;
         end
         if (wr_tx && !tx_full) begin
            tx_hold_q <= wdata_q[7:0];
            if (hci_mode_q) tx_pend_q <= 1'b1;
            else tx_req_q <= !tx_req_q;
         end else if (tx_pend_q && u_tx_rdy) begin
            tx_pend_q <= 1'b0;
         end
         miso_oe_q <= spi_on && (single_q || !cs_n_s);
      end
   end
   assign spi_miso_oe_out = miso_oe_q;
   assign osc_start_out = osc_start_q;
   assign osc_en_out = osc_en_q;

   // ==========================================================
   // Checks
   sequence word_end_s;
      bit_cnt_q == 3'h7;
   endsequence
   sequence word_done_s;
      bit_cnt_q == 3'h0 ##0 $changed(rx_tog_q);
   endsequence
   cnt_clear_a: assert property (@(posedge clk_in)
      spi_cs_n_in |-> bit_cnt_q == 3'h0) else $error("bit counter not cleared");
   word_len_a: assert property (@(posedge spi_sclk_in) disable iff (spi_cs_n_in || !rstn_in)
      word_end_s |=> word_done_s) else $error("word not eight bits");
   mode3_shift_a: assert property (@(negedge spi_sclk_in) disable iff (spi_cs_n_in || !rstn_in)
      bit_cnt_q != 3'h0 |-> ##0 1'b1 ##1 (bit_cnt_q == 3'h0 || miso_q == $past(tx_sh_q[7])))
      else $error("serial out bit order wrong");
   multi_release_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      (cs_n_s && !single_q) [*2] |-> !miso_oe_q) else $error("shared line not released");
   single_drive_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      (spi_on && single_q) [*2] |-> miso_oe_q) else $error("sole slave not driving");
   hci_only_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      hci_mode_q |-> !miso_oe_q ##0 !spi_rx_evt) else $error("slave link active in hci");
   mode_hold_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      boot_done_q |=> $stable(hci_mode_q) && boot_done_q) else $error("mode changed");
   wake_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      (asleep_q && wake_s) |=> osc_start_q && osc_en_out ##1 !osc_start_q)
      else $error("wake did not restart oscillator");
endmodule

// *** dv/hsi_host_model.sv ***
`timescale 1ns/100ps
// ==========================================================
// Host side of both links
module hsi_host_model #(
   parameter int BIT_NS = hsi_pkg::BAUD_DIV * 100,
   parameter int HALF_NS = 320
) (
   input wire logic strap_low_in, // Boot strap low
   output logic sclk_out, // Serial clock
   output logic cs_n_out, // Select, low
   output logic mosi_out, // Host data out
   input wire logic miso_in, // Device data out
   input wire logic miso_oe_in, // Device drive enable
   output logic rxd_out, // Into device receive pin
   input wire logic txd_in // From device transmit pin
);
   import hsi_pkg::*;
   logic rxd_q;
   logic miso_w;
   // Pull-up while the device releases the line
   assign miso_w = miso_oe_in ? miso_in : 1'b1;
   assign rxd_out = strap_low_in ? 1'b0 : rxd_q;
   initial begin
      sclk_out = 1'b1;
      cs_n_out = 1'b1;
      mosi_out = 1'b0;
      rxd_q = 1'b1;
   end
   task automatic spi_sel(input logic on);
      cs_n_out = !on;
      if (!on) begin
         mosi_out = !mosi_out;
      end
      #(HALF_NS);
   endtask
   task automatic spi_bits(input logic [7:0] tx, input int n, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i >= 8 - n; i--) begin
         sclk_out = 1'b0;
         mosi_out = tx[i];
         #(HALF_NS);
         sclk_out = 1'b1;
         rx[i] = miso_w;
         #(HALF_NS);
      end
   endtask
   task automatic uart_send(input logic [7:0] b);
      rxd_q = 1'b0;
      #(BIT_NS);
      for (int i = 0; i < 8; i++) begin
         rxd_q = b[i];
         #(BIT_NS);
      end
      rxd_q = 1'b1;
      #(BIT_NS);
   endtask
   task automatic uart_recv(output logic [7:0] b, output logic stop);
      @(negedge txd_in);
      #(BIT_NS + BIT_NS / 2);
      for (int i = 0; i < 8; i++) begin
         b[i] = txd_in;
         #(BIT_NS);
      end
      stop = txd_in;
   endtask
endmodule

// *** dv/hsi_top_bench.sv ***
`timescale 1ns/100ps
module hsi_top_bench;
   import hsi_pkg::*;
   logic clk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0;
   logic [31:0] wdata = 32'h0, rdata;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic wake_n = 1'b1, alt_n = 1'b1, strap_low = 1'b0;
   logic [3:0] wstrb = 4'hF;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic sclk, cs_n, mosi, miso, oe, rxd, txd, osc_start, osc_en;
   int err_total = 0;
   int total_checks = 0;
   always #50 clk_in = ~clk_in;
   hsi_top u_hsi_top (.clk_in(clk_in), .rstn_in(rstn_in), .s_axi_awaddr_in(awaddr),
      .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
      .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
      .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
      .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
      .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
      .s_axi_rready_in(rready), .spi_sclk_in(sclk), .spi_cs_n_in(cs_n), .spi_mosi_in(mosi),
      .spi_miso_out(miso), .spi_miso_oe_out(oe), .uart_rxd_in(rxd), .uart_txd_out(txd),
      .wake_req_n_in(wake_n), .alternate_wake_pin_n_in(alt_n), .osc_start_out(osc_start),
      .osc_en_out(osc_en));
   hsi_host_model u_hsi_host_model (.strap_low_in(strap_low), .sclk_out(sclk),
      .cs_n_out(cs_n), .mosi_out(mosi), .miso_in(miso), .miso_oe_in(oe), .rxd_out(rxd),
      .txd_in(txd));
   // ==========================================================
   // Checking and bus tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up;
      if (err_total == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic do_reset(input logic low);
      @(posedge clk_in);
      rstn_in <= 1'b0;
      strap_low <= low;
      repeat (3) @(posedge clk_in);
      rstn_in <= 1'b1;
      repeat (8) @(posedge clk_in);
   endtask
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_in);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk_in);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1) break;
      end
      bready <= 1'b0;
      chk(bresp, RESP_OKAY);
      if (n == 50) err_total++;
   endtask
   task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge clk_in);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk_in);
         if (arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1) break;
      end
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      if (n == 50) err_total++;
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_hci;
      logic [31:0] d;
      logic [1:0] r;
      logic [7:0] b;
      logic s;
      do_reset(1'b0);
      axi_rd(OFS_STAT, d, r);
      chk(d[STAT_HCI_BIT], 1'b1);
      axi_rd(4'h2, d, r);
      chk(r, RESP_SLVERR);
      chk(d, 32'h0);
      fork
         u_hsi_host_model.uart_recv(b, s);
         axi_wr(OFS_TXDATA, 32'h000000A5);
      join
      chk(b, 8'hA5);
      chk(s, 1'b1);
      u_hsi_host_model.uart_send(8'h3C);
      for (int i = 0; i < 10; i++) begin
         axi_rd(OFS_STAT, d, r);
         if (d[STAT_RXV_BIT] === 1'b1) break;
      end
      axi_rd(OFS_RXDATA, d, r);
      chk(d, 32'h3C);
      chk(oe, 1'b0);
   endtask
   task automatic t_wake(input logic alt);
      logic seen;
      axi_wr(OFS_CTRL, 32'h2);
      repeat (3) @(posedge clk_in);
      chk(osc_en, 1'b0);
      if (alt) alt_n <= 1'b0;
      else wake_n <= 1'b0;
      seen = 1'b0;
      repeat (10) begin
         @(posedge clk_in);
         if (osc_start === 1'b1) seen = 1'b1;
      end
      chk(seen, 1'b1);
      chk(osc_en, 1'b1);
      alt_n <= 1'b1;
      wake_n <= 1'b1;
   endtask
   task automatic t_spi;
      logic [31:0] d;
      logic [1:0] r;
      logic [7:0] m1, m2;
      do_reset(1'b1);
      axi_rd(OFS_STAT, d, r);
      chk(d[STAT_HCI_BIT], 1'b0);
      axi_rd(OFS_CTRL, d, r);
      chk(d[CTRL_SINGLE_BIT], CTRL_SINGLE_RST);
      axi_wr(OFS_TXDATA, 32'h5A);
      u_hsi_host_model.spi_sel(1'b1);
      u_hsi_host_model.spi_bits(8'hFF, 3, m1);
      u_hsi_host_model.spi_sel(1'b0);
      repeat (5) @(posedge clk_in);
      chk(oe, 1'b0);
      u_hsi_host_model.spi_sel(1'b1);
      repeat (4) @(posedge clk_in);
      chk(oe, 1'b1);
      u_hsi_host_model.spi_bits(8'h96, 8, m1);
      u_hsi_host_model.spi_bits(8'h81, 8, m2);
      u_hsi_host_model.spi_sel(1'b0);
      chk(m1, 8'h5A);
      chk(m2, 8'h00);
      repeat (10) @(posedge clk_in);
      axi_rd(OFS_RXDATA, d, r);
      chk(d, 32'h81);
      axi_wr(OFS_CTRL, 32'h1);
      axi_rd(OFS_CTRL, d, r);
      chk(d[CTRL_SINGLE_BIT], 1'b1);
      wstrb <= 4'hE;
      axi_wr(OFS_CTRL, 32'h0);
      wstrb <= 4'hF;
      axi_rd(OFS_CTRL, d, r);
      chk(d[CTRL_SINGLE_BIT], 1'b1);
      repeat (4) @(posedge clk_in);
      chk(oe, 1'b1);
   endtask
   initial begin
      repeat (60000) @(posedge clk_in);
      err_total++;
      wrap_up();
   end
   initial begin
      t_hci();
      t_wake(1'b0);
      t_wake(1'b1);
      t_spi();
      wrap_up();
   end
endmodule
